// file: common/bfc_consts.svh
`ifndef BFC_CONSTS_SVH
`define BFC_CONSTS_SVH
// register byte offsets
`define BFC_OFF_CMD     8'h00
`define BFC_OFF_OPER    8'h04
`define BFC_OFF_PC      8'h08
`define BFC_OFF_ZPTR    8'h0C
`define BFC_OFF_TGT     8'h10
`define BFC_OFF_STACK   8'h14
`define BFC_OFF_STATUS_REGISTER    8'h18
`define BFC_OFF_STAT    8'h1C
// widths
`define BFC_PCW         22
// command field positions
`define BFC_CMD_OP_LSB  0
`define BFC_CMD_SEL_LSB 5
`define BFC_CMD_TWO     8
// status register flag positions
`define BFC_F_C         0
`define BFC_F_Z         1
`define BFC_F_N         2
`define BFC_F_V         3
`define BFC_F_S         4
`define BFC_F_H         5
`define BFC_F_T         6
`define BFC_F_I         7
// reset values
`define BFC_RST_PC      22'h000000
`define BFC_RST_STATUS_REGISTER    8'h00
// cycle counts
`define BFC_CYC_ONE     3'h1
`define BFC_CYC_TWO     3'h2
`define BFC_CYC_THREE   3'h3
`define BFC_CYC_FOUR    3'h4
`define BFC_CYC_FIVE    3'h5
`endif

// file: common/bfc_pkg.sv
package bfc_pkg;
  // instruction selector written to the command register
  typedef enum logic [4:0] {
    BFC_INDIRECT_SUBROUTINE_JUMP = 5'h00,
    BFC_EXTENDED_INDIRECT_JUMP   = 5'h01,
    BFC_CALL_DIRECT              = 5'h02,
    BFC_SUBROUTINE_EXIT          = 5'h03,
    BFC_INTERRUPT_EXIT           = 5'h04,
    BFC_COMPARE_SKIP_EQUAL       = 5'h05,
    BFC_COMPARE_REGISTERS        = 5'h06,
    BFC_COMPARE_WITH_CARRY       = 5'h07,
    BFC_COMPARE_IMMEDIATE        = 5'h08,
    BFC_SKIP_REG_BIT_CLEAR       = 5'h09,
    BFC_SKIP_REG_BIT_SET         = 5'h0A,
    BFC_SKIP_IO_BIT_CLEAR        = 5'h0B,
    BFC_SKIP_IO_BIT_SET          = 5'h0C,
    BFC_BRANCH_FLAG_SET          = 5'h0D,
    BFC_BRANCH_FLAG_CLEAR        = 5'h0E,
    BFC_COPY_REGISTER            = 5'h0F,
    BFC_COPY_REGISTER_PAIR       = 5'h10,
    BFC_LOAD_IMMEDIATE           = 5'h11
  } bfc_op_e;

  typedef enum logic [1:0] {
    BFC_IDLE = 2'b01,
    BFC_EXEC = 2'b10
  } bfc_state_e;

  typedef struct packed {
    bfc_state_e  st;
    logic [2:0]  cnt;
    logic [21:0] pc;
    logic [21:0] npc;
    logic [15:0] z;
    logic [5:0]  ext;
    logic [21:0] tgt;
    logic [21:0] stk;
    logic [7:0]  status_register;
    logic [7:0]  nsreg;
    logic [7:0]  a;
    logic [7:0]  b;
    logic [8:0]  cmd;
    logic [15:0] res;
    logic        resv;
    logic        pair;
    logic [2:0]  cyc;
    logic        rdy;
    logic        err;
    logic [31:0] rdata;
  } bfc_state_s;
endpackage

// file: src/bfc_cmp.sv
`timescale 1ns/100ps
`default_nettype none
`include "bfc_consts.svh"
module bfc_cmp (
  // operands
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       use_carry,
  input  wire logic [7:0] status_register,
  // flags out
  output logic      [7:0] flags
);
  import bfc_pkg::*;
  logic [7:0] r;
  logic       ci;

  // difference and flag equations
  always_comb begin
    ci    = use_carry & status_register[`BFC_F_C];
    r     = a - b - {7'h00, ci};
    flags = status_register;
    flags[`BFC_F_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
    flags[`BFC_F_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    flags[`BFC_F_N] = r[7];
    flags[`BFC_F_S] = r[7] ^ flags[`BFC_F_V]; // see RL14
    flags[`BFC_F_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
    // carry form keeps zero only across a chain
    flags[`BFC_F_Z] = (r == 8'h00) & (~use_carry | status_register[`BFC_F_Z]);
  end
endmodule
`default_nettype wire

// file: src/bfc_core.sv
// Summary of operation
// RL1: indirect jump: pc from Z, upper zero
// RL2: extended jump: upper pc from extension, 3 cycles
// RL3: direct call loads absolute target, 3/4 cycles
// RL4: subroutine exit restores pc, 4/5 cycles
// RL5: interrupt exit restores pc, sets I
// RL6: compare-skip-equal skips when operands equal
// RL7: compares set six flags, no result written
// RL8: register bit test skips on selected value
// RL9: io bit test skips, one extra cycle
// RL10: flag branch adds offset plus one
// RL11: equal branches follow zero flag
// RL12: carry and lower/higher branches follow carry
// RL13: minus and plus branches follow negative
// RL14: signed branches follow N xor V
// RL15: half-carry branches follow half-carry flag
// RL16: transfer-bit branches follow T flag
// RL17: overflow branches follow overflow flag
// RL18: interrupt branches follow interrupt enable
// RL19: register and pair copy, one cycle
// RL20: load immediate writes constant, one cycle
// RL21: skip length follows next instruction size
// RL22: branch 1 cycle untaken, 2 taken, signed
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "bfc_consts.svh"
module bfc_core #(
  parameter bit PC_WIDE = 1'b0
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // core state
  output logic             busy,
  output logic [21:0]      pc_out
);
  import bfc_pkg::*;

  // count selector refused at elaboration unless 0 or 1
  if (PC_WIDE !== 1'b0 && PC_WIDE !== 1'b1) begin : g_bad_wide
    $error("PC_WIDE must be 0 or 1");
  end

  bfc_state_s q;
  bfc_state_s d;
  logic [7:0] cmp_flags;
  logic       acc;
  logic       wr;
  logic       go;
  logic       hit;
  bfc_op_e    op;
  logic [2:0] sel;
  logic       bitv;
  logic       skip;
  logic [2:0] skip_cyc;
  logic [2:0] wide;

  // ----------------------------------------------------------------
  // compare unit
  // ----------------------------------------------------------------
  bfc_cmp u_cmp (
    .a         (q.a),
    .b         (q.b),
    .use_carry (pwdata[4:0] == BFC_COMPARE_WITH_CARRY),
    .status_register      (q.status_register),
    .flags     (cmp_flags)
  );

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // access phase committing at this edge
  assign acc  = psel & penable & q.rdy;
  assign wr   = acc & pwrite & ~q.err;
  assign go   = wr & (paddr == `BFC_OFF_CMD);
  assign hit  = (paddr[1:0] == 2'b00) && (paddr <= `BFC_OFF_STAT);
  assign op   = bfc_op_e'(pwdata[`BFC_CMD_SEL_LSB-1:`BFC_CMD_OP_LSB]);
  assign sel  = pwdata[`BFC_CMD_SEL_LSB+2:`BFC_CMD_SEL_LSB];
  assign bitv = q.a[sel];
  assign wide = PC_WIDE ? 3'h1 : 3'h0;
  // one word skipped in 2 cycles, two words in 3
  assign skip_cyc = pwdata[`BFC_CMD_TWO] ? `BFC_CYC_THREE : `BFC_CYC_TWO; // see RL21

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d    = q;
    skip = 1'b0;
    // one wait state, held off while executing
    d.rdy = psel & penable & ~q.rdy & (q.st == BFC_IDLE);
    if (psel & penable & ~q.rdy & (q.st == BFC_IDLE)) begin
      d.err = ~hit;
      unique case (paddr)
        `BFC_OFF_CMD:   d.rdata = {23'h000000, q.cmd};
        `BFC_OFF_OPER:  d.rdata = {16'h0000, q.b, q.a};
        `BFC_OFF_PC:    d.rdata = {10'h000, q.pc};
        `BFC_OFF_ZPTR:  d.rdata = {10'h000, q.ext, q.z};
        `BFC_OFF_TGT:   d.rdata = {10'h000, q.tgt};
        `BFC_OFF_STACK: d.rdata = {10'h000, q.stk};
        `BFC_OFF_STATUS_REGISTER:  d.rdata = {24'h000000, q.status_register};
        `BFC_OFF_STAT:  d.rdata = {8'h00, q.res, 2'b00, q.cyc, q.pair, q.resv, 1'b0};
        default:        d.rdata = 32'h00000000;
      endcase
    end else begin
      d.err   = 1'b0;
      d.rdata = q.rdata;
    end
    // register writes
    if (wr) begin
      unique case (paddr)
        `BFC_OFF_OPER:  {d.b, d.a} = pwdata[15:0];
        `BFC_OFF_PC:    d.pc = pwdata[21:0];
        `BFC_OFF_ZPTR:  {d.ext, d.z} = pwdata[21:0];
        `BFC_OFF_TGT:   d.tgt = pwdata[21:0];
        `BFC_OFF_STACK: d.stk = pwdata[21:0];
        `BFC_OFF_STATUS_REGISTER:  d.status_register = pwdata[7:0];
        default:        d.cmd = q.cmd;
      endcase
    end
    // instruction launch
    if (go) begin
      d.cmd   = pwdata[8:0];
      d.st    = BFC_EXEC;
      d.npc   = q.pc + 22'h000001;
      d.nsreg = q.status_register;
      d.resv  = 1'b0;
      d.pair  = 1'b0;
      d.res   = q.res;
      d.cyc   = `BFC_CYC_ONE;
      unique case (op)
        BFC_INDIRECT_SUBROUTINE_JUMP: begin
          d.npc = {6'h00, q.z}; // see RL1
          d.cyc = `BFC_CYC_TWO + wide;
        end
        BFC_EXTENDED_INDIRECT_JUMP: begin
          d.npc = {q.ext, q.z}; // see RL2
          d.cyc = `BFC_CYC_THREE;
        end
        BFC_CALL_DIRECT: begin
          d.npc = q.tgt; // see RL3
          d.cyc = `BFC_CYC_THREE + wide;
        end
        BFC_SUBROUTINE_EXIT: begin
          d.npc = q.stk; // see RL4
          d.cyc = `BFC_CYC_FOUR + wide;
        end
        BFC_INTERRUPT_EXIT: begin
          d.npc = q.stk;
          d.nsreg[`BFC_F_I] = 1'b1; // see RL5
          d.cyc = `BFC_CYC_FOUR + wide;
        end
        BFC_COMPARE_SKIP_EQUAL: skip = (q.a == q.b); // see RL6
        BFC_COMPARE_REGISTERS, BFC_COMPARE_WITH_CARRY, BFC_COMPARE_IMMEDIATE: begin
          d.nsreg = cmp_flags; // see RL7
        end
        BFC_SKIP_REG_BIT_CLEAR: skip = ~bitv; // see RL8
        BFC_SKIP_REG_BIT_SET:   skip = bitv;
        BFC_SKIP_IO_BIT_CLEAR, BFC_SKIP_IO_BIT_SET: begin
          // io read costs one more cycle
          skip  = bitv ^ (op == BFC_SKIP_IO_BIT_CLEAR); // see RL9
          d.cyc = `BFC_CYC_TWO;
        end
        BFC_BRANCH_FLAG_SET, BFC_BRANCH_FLAG_CLEAR: begin
          // sel picks C,Z,N,V,S,H,T,I for the named branches
          // see RL11 RL12 RL13 RL14 RL15 RL16 RL17 RL18
          if (q.status_register[sel] == (op == BFC_BRANCH_FLAG_SET)) begin
            d.npc = q.pc + 22'h000001 + {{15{q.tgt[6]}}, q.tgt[6:0]}; // see RL10
            d.cyc = `BFC_CYC_TWO; // see RL22
          end
        end
        BFC_COPY_REGISTER, BFC_LOAD_IMMEDIATE: begin
          d.res  = {8'h00, q.b}; // see RL19 RL20
          d.resv = 1'b1;
        end
        BFC_COPY_REGISTER_PAIR: begin
          d.res  = {q.b, q.a}; // see RL19
          d.resv = 1'b1;
          d.pair = 1'b1;
        end
        default: d.st = BFC_IDLE;
      endcase
      if (skip) begin
        d.npc = q.pc + 22'h000002 + {21'h000000, pwdata[`BFC_CMD_TWO]}; // see RL21
        d.cyc = d.cyc + skip_cyc - `BFC_CYC_ONE;
      end
      d.cnt = d.cyc - 3'h1;
    end
    // retire after the instruction's cycle count
    if (q.st == BFC_EXEC) begin
      d.cnt = q.cnt - 3'h1;
      if (q.cnt == 3'h0) begin
        d.st   = BFC_IDLE;
        d.pc   = q.npc;
        d.status_register = q.nsreg;
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q       <= '0;
      q.st    <= BFC_IDLE;
      q.pc    <= `BFC_RST_PC;
      q.status_register  <= `BFC_RST_STATUS_REGISTER;
    end else begin
      q <= d;
    end
  end

  // outputs from flops
  assign pready  = q.rdy;
  assign prdata  = q.rdata;
  assign pslverr = q.err;
  assign busy    = q.st[1]; // one-hot execute bit
  assign pc_out  = q.pc;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic    done;
  bfc_op_e cur;
  assign done = (q.st == BFC_EXEC) && (q.cnt == 3'h0);
  assign cur  = bfc_op_e'(q.cmd[4:0]);

  sequence s_copy_go;
    go && (op == BFC_COPY_REGISTER);
  endsequence
  sequence s_one_cycle;
    (q.st == BFC_EXEC) ##1 (q.st == BFC_IDLE) && q.resv;
  endsequence

  AST_INDIRECT: assert property (done && cur == BFC_INDIRECT_SUBROUTINE_JUMP |=> // see RL1
    q.pc == {6'h00, $past(q.z)} && q.status_register == $past(q.status_register))
    else $error("indirect jump pc or flags wrong");
  AST_EXTENDED: assert property (done && cur == BFC_EXTENDED_INDIRECT_JUMP |=> // see RL2
    q.pc == {q.ext, q.z} && q.cyc == 3'h3)
    else $error("extended jump pc or cycles wrong");
  AST_CALL: assert property (done && cur == BFC_CALL_DIRECT |=> // see RL3
    q.pc == q.tgt && q.cyc == 3'h3 + wide)
    else $error("direct call wrong");
  AST_IRQ_EXIT: assert property (done && cur == BFC_INTERRUPT_EXIT |=> // see RL5
    q.status_register[7] && q.pc == q.stk)
    else $error("interrupt exit wrong");
  AST_COMPARE_SKIP_EQUAL: assert property (done && cur == BFC_COMPARE_SKIP_EQUAL |=> // see RL6
    (q.pc == $past(q.pc) + 22'h000001) == (q.a != q.b))
    else $error("compare skip decision wrong");
  AST_CMP_ZERO: assert property (done && cur == BFC_COMPARE_REGISTERS |=> // see RL7
    q.status_register[1] == (q.a == q.b) && !q.resv && q.cyc == 3'h1)
    else $error("compare zero flag wrong");
  AST_BRANCH: assert property (done && (cur == BFC_BRANCH_FLAG_SET || cur == BFC_BRANCH_FLAG_CLEAR) |=> // see RL22
    q.pc == $past(q.pc) + 22'h000001 + ((q.cyc == 3'h2) ? {{15{q.tgt[6]}}, q.tgt[6:0]} : 22'h000000))
    else $error("branch cycles disagree with target");
  AST_COPY: assert property (s_copy_go |=> s_one_cycle) // see RL19
    else $error("register copy not one cycle");
  AST_BUSY_STALL: assert property ((q.st == BFC_EXEC) |-> !pready) // bus held off while executing, our own choice
    else $error("bus answered while executing");

  // per-instruction results seen the cycle after retire
  AST_INDIRECT_SUBROUTINE_JUMP_LEN: assert property (done && cur == BFC_INDIRECT_SUBROUTINE_JUMP |=> // see RL1
    q.cyc == 3'h2 + wide)
    else $error("indirect jump cycles wrong");
  AST_SUB_EXIT: assert property (done && cur == BFC_SUBROUTINE_EXIT |=> // see RL4
    q.pc == q.stk && q.status_register == $past(q.status_register) && q.cyc == 3'h4 + wide)
    else $error("subroutine exit wrong");
  AST_IRQ_EXIT_LEN: assert property (done && cur == BFC_INTERRUPT_EXIT |=> // see RL5
    q.cyc == 3'h4 + wide && q.status_register[6:0] == $past(q.status_register[6:0]))
    else $error("interrupt exit cycles or flags wrong");
  AST_CMP_CARRY: assert property (done && cur == BFC_COMPARE_WITH_CARRY |=> // see RL7
    !q.status_register[`BFC_F_Z] || $past(q.status_register[`BFC_F_Z]))
    else $error("carry compare set zero flag");
  AST_CMP_IMM: assert property (done && cur == BFC_COMPARE_IMMEDIATE |=> // see RL7
    q.status_register[`BFC_F_Z] == (q.a == q.b) && !q.resv && q.status_register[`BFC_F_I] == $past(q.status_register[`BFC_F_I]))
    else $error("immediate compare wrong");
  AST_CMP_SIGN: assert property (done && (cur == BFC_COMPARE_REGISTERS || cur == BFC_COMPARE_IMMEDIATE) |=> // see RL14
    q.status_register[`BFC_F_S] == (q.status_register[`BFC_F_N] ^ q.status_register[`BFC_F_V]))
    else $error("sign flag not N xor V");
  AST_REG_SKIP: assert property (done && (cur == BFC_SKIP_REG_BIT_CLEAR || cur == BFC_SKIP_REG_BIT_SET) |=> // see RL8
    (q.cyc == 3'h1) == (q.pc == $past(q.pc) + 22'h000001) && q.status_register == $past(q.status_register))
    else $error("register bit skip wrong");
  AST_IO_SKIP: assert property (done && (cur == BFC_SKIP_IO_BIT_CLEAR || cur == BFC_SKIP_IO_BIT_SET) |=> // see RL9
    (q.cyc == 3'h2) == (q.pc == $past(q.pc) + 22'h000001) && q.cyc >= 3'h2)
    else $error("io bit skip wrong");
  AST_BRANCH_COND: assert property (done && (cur == BFC_BRANCH_FLAG_SET || cur == BFC_BRANCH_FLAG_CLEAR) |=> // see RL18
    (q.cyc == 3'h2) == (q.status_register[q.cmd[7:5]] == (cur == BFC_BRANCH_FLAG_SET)))
    else $error("branch taken against its flag");
  AST_SKIP_TWO: assert property (done && cur == BFC_COMPARE_SKIP_EQUAL && q.a == q.b |=> // see RL21
    q.pc == $past(q.pc) + 22'h000002 + {21'h000000, q.cmd[`BFC_CMD_TWO]})
    else $error("skip length wrong");
  AST_PAIR: assert property (done && cur == BFC_COPY_REGISTER_PAIR |=> // see RL19
    q.res == {q.b, q.a} && q.pair && q.status_register == $past(q.status_register))
    else $error("pair copy wrong");
  AST_LOAD: assert property (done && cur == BFC_LOAD_IMMEDIATE |=> // see RL20
    q.res == {8'h00, q.b} && q.resv && q.status_register == $past(q.status_register) && q.cyc == 3'h1)
    else $error("immediate load wrong");
endmodule
`default_nettype wire

// file: tb/bfc_apb_master.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// apb master standing in for the cpu side
// ----------------------------------------
module bfc_apb_master (
  // clock
  input  wire logic        pclk,
  // apb request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  // apb answer
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  // idle bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // one transfer, held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// flow control bench
// ----------------------------------------
module tb_top;
  import bfc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, busy, e, tk;
  logic [7:0]  paddr, sv;
  logic [31:0] pwdata, prdata, q;
  logic [21:0] pc_out;
  int          num_errors = 0;
  int          n_tests = 0;
  int          cyc = 0;

  bfc_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .busy(busy), .pc_out(pc_out));
  bfc_apb_master i_mst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

  // 125 MHz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_mst.xfer(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a);
    i_mst.xfer(1'b0, a, 32'h0, q, e);
  endtask

  // one instruction from pc 0x10, then pc and cycle count
  task automatic run(input logic [4:0] op, input logic [2:0] s, input logic two,
                     input logic [21:0] pce, input logic [2:0] cy);
    wr(8'h08, 32'h10);
    wr(8'h00, {23'h0, two, s, op});
    @(posedge pclk);
    check("busy", {31'h0, busy}, 32'h1);
    rd(8'h08);
    check("pc", q, {10'h0, pce});
    check("pc_out", {10'h0, pc_out}, {10'h0, pce});
    rd(8'h1C);
    check("cycles", {29'h0, q[5:3]}, {29'h0, cy});
  endtask

  // main sequence
  initial begin
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h18);
    check("status_register_rst", q, 32'h0);
    rd(8'h20);
    check("slverr", {31'h0, e}, 32'h1);
    check("unmapped_rd", q, 32'h0);
    wr(8'h0C, 32'h003F1234);
    run(BFC_INDIRECT_SUBROUTINE_JUMP, 3'h0, 1'b0, 22'h001234, 3'h2);
    run(BFC_EXTENDED_INDIRECT_JUMP, 3'h0, 1'b0, 22'h3F1234, 3'h3);
    wr(8'h10, 32'h002ABCDE);
    run(BFC_CALL_DIRECT, 3'h0, 1'b0, 22'h2ABCDE, 3'h3);
    wr(8'h14, 32'h00000100);
    run(BFC_SUBROUTINE_EXIT, 3'h0, 1'b0, 22'h000100, 3'h4);
    rd(8'h18);
    check("status_register_ret", q, 32'h0);
    run(BFC_INTERRUPT_EXIT, 3'h0, 1'b0, 22'h000100, 3'h4);
    rd(8'h18);
    check("status_register_interrupt_exit", q, 32'h80);
    wr(8'h04, 32'h2010);
    run(BFC_COMPARE_IMMEDIATE, 3'h0, 1'b0, 22'h11, 3'h1);
    rd(8'h18);
    check("status_register_cpi", q, 32'h95);
    run(BFC_COMPARE_WITH_CARRY, 3'h0, 1'b0, 22'h11, 3'h1);
    rd(8'h18);
    check("status_register_cpc", q, 32'hB5);
    run(BFC_COMPARE_REGISTERS, 3'h0, 1'b0, 22'h11, 3'h1);
    check("cp_stat", q, 32'h00000008);
    rd(8'h18);
    check("status_register_cp", q, 32'h95);
    // branches on every flag, both variants, offset minus two
    wr(8'h10, 32'h7E);
    for (int j = 0; j < 2; j++) begin
      sv = j[0] ? 8'h6A : 8'h95;
      wr(8'h18, {24'h0, sv});
      for (int i = 0; i < 16; i++) begin
        tk = sv[i[2:0]] ^ i[3];
        run(i[3] ? BFC_BRANCH_FLAG_CLEAR : BFC_BRANCH_FLAG_SET, i[2:0], 1'b0,
            tk ? 22'h0F : 22'h11, tk ? 3'h2 : 3'h1);
      end
    end
    wr(8'h04, 32'h0404);
    run(BFC_COMPARE_SKIP_EQUAL, 3'h0, 1'b0, 22'h12, 3'h2);
    run(BFC_COMPARE_SKIP_EQUAL, 3'h0, 1'b1, 22'h13, 3'h3);
    run(BFC_SKIP_REG_BIT_SET, 3'h2, 1'b0, 22'h12, 3'h2);
    run(BFC_SKIP_REG_BIT_CLEAR, 3'h2, 1'b0, 22'h11, 3'h1);
    run(BFC_SKIP_IO_BIT_SET, 3'h2, 1'b1, 22'h13, 3'h4);
    run(BFC_SKIP_IO_BIT_CLEAR, 3'h2, 1'b0, 22'h11, 3'h2);
    wr(8'h04, 32'h0504);
    run(BFC_COMPARE_SKIP_EQUAL, 3'h0, 1'b0, 22'h11, 3'h1);
    run(BFC_COPY_REGISTER, 3'h0, 1'b0, 22'h11, 3'h1);
    check("mov_stat", q, 32'h0000050A);
    run(BFC_COPY_REGISTER_PAIR, 3'h0, 1'b0, 22'h11, 3'h1);
    check("copy_register_pair_stat", q, 32'h0005040E);
    run(BFC_LOAD_IMMEDIATE, 3'h0, 1'b0, 22'h11, 3'h1);
    check("ldi_stat", q, 32'h0000050A);
    rd(8'h18);
    check("status_register_kept", q, 32'h6A);
    // reset in mid-run clears pc and flags
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    check("busy_rst", {31'h0, busy}, 32'h0);
    rd(8'h08);
    check("pc_rst", q, 32'h0);
    rd(8'h18);
    check("status_register_rst2", q, 32'h0);
    final_report();
  end
endmodule
`default_nettype wire
